// *** bms_slave.sv ***
// Message broadcast receive slave: area decode, two channels, local registers
//
// Operation
// R01 - The control register holds the board slot code in bits 4..0, codes 01h to 15h for slots 1 to 21.
// R02 - A bus access is inside the broadcast area only when A31..A24 equal the area register.
// R03 - Area register bit 7 is compared with A31 down to bit 0 with A24.
// R04 - There are four interrupt control registers: ch0 message, ch0 refused, ch1 message, ch1 refused.
// R05 - Bit 3 of each interrupt control register enables its interrupt channel.
// R06 - Bits 2..0 of each interrupt control register pick level 1 to 7, with 000 disabling it.
// R07 - Each message status register reads bit 7 low while that message interrupt is pending.
// R08 - A message interrupt drops once that channel's storage is empty.
// R09 - Each refused status register reads bit 7 low while pending and any write to it clears it.
// R10 - Each readout register is read-only and gives the message byte on bits 7..0, upper bits zero.
// R11 - Each channel has its own readout register returning only its own messages.
// R12 - Channel 0 queues eight bytes; channel 1 holds one byte and refuses more until it is read.
// R13 - Reading a readout register while its storage is empty ends with a bus error.
// R14 - A broadcast to a channel whose storage is full is refused and raises its refused interrupt.
// R15 - Control bits 5 and 6 enable channels 0 and 1; bit 7 admits modifier 09h besides 0Dh.
// R16 - Each successful readout removes the oldest message, so messages leave in arrival order.
`timescale 1ns/1ns
module bms_slave #(
   parameter int CH0_DEPTH = bms_pkg::CH0_DEPTH,
   parameter int CH1_DEPTH = bms_pkg::CH1_DEPTH
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Local CPU register access
   input  wire logic        cpu_req,
   input  wire logic        cpu_wr,
   input  wire logic [31:0] cpu_addr,
   input  wire logic [31:0] cpu_wdata,
   output logic [31:0]      cpu_rdata_r,
   output logic             cpu_ack_r,
   output logic             cpu_berr_r,
   // Broadcast cycles from the system bus
   input  wire logic        vme_req,
   input  wire logic        vme_wr,
   input  wire logic [31:0] vme_addr,
   input  wire logic [5:0]  vme_am,
   input  wire logic [7:0]  vme_data,
   output logic             vme_ack_r,
   output logic             vme_refused_r,
   // Interrupt request to the local CPU
   output logic [2:0]       irq_level_r,
   output logic [1:0]       irq_source_r
);
   localparam int MW = bms_pkg::MSG_W;

   // Register state
   logic [7:0]           control_r;
   logic [7:0]           area_r;
   logic [3:0]           icr_r [bms_pkg::NUM_SRC];
   logic [1:0]           refused_r;

   // Control fields
   logic [4:0]           board_slot_number;
   logic                 channel0_enable;
   logic                 channel1_enable;
   logic                 allow_nonprivileged_access;

   // Broadcast decode
   logic [7:0]           area_match_bits;
   logic                 area_hit;
   logic                 am_ok;
   logic                 slot_valid;
   logic [5:0]           slot_line;
   logic                 slot_hit;
   logic                 chan_sel;
   logic                 chan_on;
   logic                 bcast;
   logic                 bcast_ch0;
   logic                 bcast_ch1;
   logic                 push0;
   logic                 push1;
   logic                 refuse0;
   logic                 refuse1;

   // Queues
   logic                 full0;
   logic                 full1;
   logic                 empty0;
   logic                 empty1;
   logic [MW-1:0]        head0;
   logic [MW-1:0]        head1;

   // Local decode
   logic                 hit_control;
   logic                 hit_area;
   logic [3:0]           hit_icr;
   logic                 hit_isr_msg0;
   logic                 hit_isr_ref0;
   logic                 hit_isr_msg1;
   logic                 hit_isr_ref1;
   logic                 hit_rd0;
   logic                 hit_rd1;
   logic                 hit_any;
   logic                 cpu_read;
   logic                 cpu_write;
   logic                 pop0;
   logic                 pop1;
   logic                 bad_access;
   logic                 ack_nxt;
   logic                 berr_nxt;
   logic [31:0]          rdata_nxt;
   logic [31:0]          icr_rdata;
   logic [1:0]           refused_clr;
   logic [1:0]           refused_nxt;

   // Interrupt selection
   logic [3:0]           src_pending;
   logic [2:0]           src_level [bms_pkg::NUM_SRC];
   logic [2:0]           level_nxt;
   logic [1:0]           source_nxt;

   // Control field split
   assign board_slot_number          = control_r[bms_pkg::CTL_SLOT_MSB:bms_pkg::CTL_SLOT_LSB]; // R01
   assign channel0_enable            = control_r[bms_pkg::CTL_CH0_EN_BIT];
   assign channel1_enable            = control_r[bms_pkg::CTL_CH1_EN_BIT];
   assign allow_nonprivileged_access = control_r[bms_pkg::CTL_USER_BIT];

   // Area compare, bit 7 against A31 down to bit 0 against A24
   assign area_match_bits = area_r; // R03
   assign area_hit = (vme_addr[bms_pkg::AREA_ADDR_MSB:bms_pkg::AREA_ADDR_LSB] == area_match_bits); // R02

   assign am_ok = (vme_am == bms_pkg::AM_EXT_SUPER) ||
                  (allow_nonprivileged_access && (vme_am == bms_pkg::AM_EXT_USER)); // R15

   // Unprogrammed or out-of-range slot code never answers
   assign slot_valid = (board_slot_number >= bms_pkg::SLOT_FIRST) &&
                       (board_slot_number <= bms_pkg::SLOT_LAST); // R01
   assign slot_line  = 6'(board_slot_number) + bms_pkg::SLOT_ADDR_BASE;
   assign slot_hit   = slot_valid && vme_addr[slot_line[4:0]];

   assign chan_sel = vme_addr[bms_pkg::CHAN_ADDR_BIT];
   assign chan_on  = chan_sel ? channel1_enable : channel0_enable; // R15

   // Reads in the area are not part of the protocol and get no answer
   assign bcast     = vme_req && vme_wr && area_hit && am_ok && slot_hit && chan_on;
   assign bcast_ch0 = bcast && !chan_sel;
   assign bcast_ch1 = bcast && chan_sel;
   assign push0     = bcast_ch0 && !full0;
   assign push1     = bcast_ch1 && !full1;
   assign refuse0   = bcast_ch0 && full0; // R14
   assign refuse1   = bcast_ch1 && full1; // R14

   // Channel 0 queue of eight, channel 1 single latch
   bms_msg_queue #(
      .WIDTH (MW),
      .DEPTH (CH0_DEPTH)
   ) u_queue_ch0 (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (push0),
      .push_data (vme_data),
      .full      (full0),
      .pop       (pop0),
      .head_data (head0),
      .empty     (empty0)
   ); // R12

   bms_msg_queue #(
      .WIDTH (MW),
      .DEPTH (CH1_DEPTH)
   ) u_queue_ch1 (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (push1),
      .push_data (vme_data),
      .full      (full1),
      .pop       (pop1),
      .head_data (head1),
      .empty     (empty1)
   ); // R12

   // Local address decode
   assign hit_control  = (cpu_addr == bms_pkg::ADDR_CONTROL);
   assign hit_area     = (cpu_addr == bms_pkg::ADDR_AREA);
   assign hit_isr_msg0 = (cpu_addr == bms_pkg::ADDR_ISR_CH0_MSG);
   assign hit_isr_ref0 = (cpu_addr == bms_pkg::ADDR_ISR_CH0_REF);
   assign hit_isr_msg1 = (cpu_addr == bms_pkg::ADDR_ISR_CH1_MSG);
   assign hit_isr_ref1 = (cpu_addr == bms_pkg::ADDR_ISR_CH1_REF);
   assign hit_rd0      = (cpu_addr == bms_pkg::ADDR_READOUT_CH0); // R11
   assign hit_rd1      = (cpu_addr == bms_pkg::ADDR_READOUT_CH1); // R11

   genvar gi;
   generate
      for (gi = 0; gi < bms_pkg::NUM_SRC; gi++) begin : g_icr
         assign hit_icr[gi] = (cpu_addr == bms_pkg::ADDR_ICR[gi]); // R04

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               icr_r[gi] <= bms_pkg::RST_ICR;
            end else if (cpu_write && hit_icr[gi]) begin
               icr_r[gi] <= cpu_wdata[bms_pkg::ICR_W-1:0]; // R05 R06
            end
         end

         bms_irq_gate u_gate (
            .pending (src_pending[gi]),
            .icr     (icr_r[gi]),
            .level   (src_level[gi])
         ); // R05 R06
      end
   endgenerate

   assign hit_any   = hit_control || hit_area || (|hit_icr) || hit_isr_msg0 || hit_isr_ref0 ||
                      hit_isr_msg1 || hit_isr_ref1 || hit_rd0 || hit_rd1;
   assign cpu_read  = cpu_req && !cpu_wr;
   assign cpu_write = cpu_req && cpu_wr;

   // Each successful readout drains the oldest entry
   assign pop0 = cpu_read && hit_rd0 && !empty0; // R16
   assign pop1 = cpu_read && hit_rd1 && !empty1; // R16

   // Empty readout or a write to a readout register is a bus error; so is an unmapped address
   assign bad_access = (cpu_read && hit_rd0 && empty0) || (cpu_read && hit_rd1 && empty1) ||
                       (cpu_write && (hit_rd0 || hit_rd1)); // R13 R10
   assign ack_nxt    = cpu_req && hit_any && !bad_access;
   assign berr_nxt   = cpu_req && (!hit_any || bad_access);

   // Read data selection; unused bits read as zero
   assign icr_rdata = ({32{hit_icr[0]}} & {28'h000_0000, icr_r[0]}) |
                      ({32{hit_icr[1]}} & {28'h000_0000, icr_r[1]}) |
                      ({32{hit_icr[2]}} & {28'h000_0000, icr_r[2]}) |
                      ({32{hit_icr[3]}} & {28'h000_0000, icr_r[3]});

   assign rdata_nxt = ({32{hit_control}}  & {24'h00_0000, control_r}) |
                      ({32{hit_area}}     & {24'h00_0000, area_r}) |
                      icr_rdata |
                      ({32{hit_isr_msg0}} & {24'h00_0000, empty0, 7'h00}) |        // R07 R08
                      ({32{hit_isr_msg1}} & {24'h00_0000, empty1, 7'h00}) |        // R07 R08
                      ({32{hit_isr_ref0}} & {24'h00_0000, !refused_r[0], 7'h00}) | // R09
                      ({32{hit_isr_ref1}} & {24'h00_0000, !refused_r[1], 7'h00}) | // R09
                      ({32{hit_rd0 && !empty0}} & {24'h00_0000, head0}) |          // R10
                      ({32{hit_rd1 && !empty1}} & {24'h00_0000, head1});           // R10

   // Refused flags: a refusal in the clearing cycle still sets the flag
   assign refused_clr = {cpu_write && hit_isr_ref1, cpu_write && hit_isr_ref0};        // R09
   assign refused_nxt = {refuse1, refuse0} | (refused_r & ~refused_clr);               // R14

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_r <= bms_pkg::RST_CONTROL;
         area_r    <= bms_pkg::RST_AREA;
      end else begin
         if (cpu_write && hit_control) control_r <= cpu_wdata[7:0]; // R01 R15
         if (cpu_write && hit_area)    area_r    <= cpu_wdata[7:0]; // R02
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         refused_r <= 2'h0;
      end else begin
         refused_r <= refused_nxt;
      end
   end

   // Local answer, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata_r <= 32'h0000_0000;
         cpu_ack_r   <= 1'b0;
         cpu_berr_r  <= 1'b0;
      end else begin
         cpu_rdata_r <= (cpu_read && ack_nxt) ? rdata_nxt : 32'h0000_0000;
         cpu_ack_r   <= ack_nxt;
         cpu_berr_r  <= berr_nxt; // R13
      end
   end

   // Broadcast answer, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vme_ack_r     <= 1'b0;
         vme_refused_r <= 1'b0;
      end else begin
         vme_ack_r     <= push0 || push1;
         vme_refused_r <= refuse0 || refuse1; // R14
      end
   end

   // Message pending while storage holds data
   assign src_pending = {refused_r[1], !empty1, refused_r[0], !empty0}; // R08

   // Highest level wins; at equal level the earlier chain position wins
   always_comb begin
      level_nxt  = 3'h0;
      source_nxt = 2'h0;
      for (int k = bms_pkg::NUM_SRC - 1; k >= 0; k--) begin
         if ((src_level[bms_pkg::IRQ_RANK[k]] != 3'h0) &&
             (src_level[bms_pkg::IRQ_RANK[k]] >= level_nxt)) begin
            level_nxt  = src_level[bms_pkg::IRQ_RANK[k]];
            source_nxt = bms_pkg::IRQ_RANK[k];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_level_r  <= 3'h0;
         irq_source_r <= 2'h0;
      end else begin
         irq_level_r  <= level_nxt; // R06
         irq_source_r <= source_nxt;
      end
   end

endmodule : bms_slave

// *** bms_pkg.sv ***
// Constants for the message broadcast receive slave
package bms_pkg;

   // Local register byte addresses
   localparam logic [31:0] ADDR_CONTROL      = 32'hFFD0_0338;
   localparam logic [31:0] ADDR_AREA         = 32'hFFD0_033C;
   localparam logic [31:0] ADDR_ICR_CH0_MSG  = 32'hFFD0_0248;
   localparam logic [31:0] ADDR_ICR_CH0_REF  = 32'hFFD0_0240;
   localparam logic [31:0] ADDR_ICR_CH1_MSG  = 32'hFFD0_024C;
   localparam logic [31:0] ADDR_ICR_CH1_REF  = 32'hFFD0_0244;
   localparam logic [31:0] ADDR_ISR_CH0_MSG  = 32'hFFD0_04E0;
   localparam logic [31:0] ADDR_ISR_CH0_REF  = 32'hFFD0_04B8;
   localparam logic [31:0] ADDR_ISR_CH1_MSG  = 32'hFFD0_04E4;
   localparam logic [31:0] ADDR_ISR_CH1_REF  = 32'hFFD0_04BC;
   localparam logic [31:0] ADDR_READOUT_CH0  = 32'hFFDC_0000;
   localparam logic [31:0] ADDR_READOUT_CH1  = 32'hFFDC_0004;

   // Interrupt source index: ch0 message, ch0 refused, ch1 message, ch1 refused
   localparam int          NUM_SRC           = 4;
   localparam logic [31:0] ADDR_ICR [NUM_SRC] = '{ADDR_ICR_CH0_MSG, ADDR_ICR_CH0_REF,
                                                 ADDR_ICR_CH1_MSG, ADDR_ICR_CH1_REF};
   // Daisy chain order, first entry wins a tie: ch1 message ahead of ch0 message
   localparam logic [1:0]  IRQ_RANK [NUM_SRC] = '{2'h2, 2'h0, 2'h3, 2'h1};

   // Control register fields
   localparam int          CTL_SLOT_LSB      = 0;
   localparam int          CTL_SLOT_MSB      = 4;
   localparam int          CTL_CH0_EN_BIT    = 5;
   localparam int          CTL_CH1_EN_BIT    = 6;
   localparam int          CTL_USER_BIT      = 7;
   localparam logic [4:0]  SLOT_FIRST        = 5'h01;
   localparam logic [4:0]  SLOT_LAST         = 5'h15;

   // Area register compares against these address lines
   localparam int          AREA_ADDR_MSB     = 31;
   localparam int          AREA_ADDR_LSB     = 24;

   // Interrupt control fields
   localparam int          ICR_EN_BIT        = 3;
   localparam int          ICR_LVL_MSB       = 2;
   localparam int          ICR_LVL_LSB       = 0;
   localparam int          ICR_W             = 4;

   // Status bit, active low
   localparam int          ISR_STATUS_BIT    = 7;

   // Reset values
   localparam logic [7:0]  RST_CONTROL       = 8'h00;
   localparam logic [7:0]  RST_AREA          = 8'h00;
   localparam logic [3:0]  RST_ICR           = 4'h0;

   // Broadcast address modifiers
   localparam logic [5:0]  AM_EXT_SUPER      = 6'h0D;
   localparam logic [5:0]  AM_EXT_USER       = 6'h09;

   // Slot n is addressed by address line n + SLOT_ADDR_BASE; channel by one line
   localparam logic [5:0]  SLOT_ADDR_BASE    = 6'h02;
   localparam int          CHAN_ADDR_BIT     = 2;

   // Message storage
   localparam int          MSG_W             = 8;
   localparam int          CH0_DEPTH         = 8;
   localparam int          CH1_DEPTH         = 1;

endpackage : bms_pkg

// *** bms_msg_queue.sv ***
// Message queue for one broadcast channel, flip-flop storage
`timescale 1ns/1ns
module bms_msg_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   output logic                  full,
   // Drain side
   input  wire logic             pop,
   output logic [WIDTH-1:0]      head_data,
   output logic                  empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [WIDTH-1:0] store_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   logic             do_push;
   logic             do_pop;

   // Push into a full queue is dropped; the caller refuses it
   assign do_push   = push && (count_r != FULL_COUNT);
   assign do_pop    = pop && (count_r != '0);
   assign full      = (count_r == FULL_COUNT);
   assign empty     = (count_r == '0);
   assign head_data = store_r[rd_ptr_r];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (do_push) wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + AW'(1);
         if (do_pop)  rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + AW'(1);
         count_r <= count_r + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge clk) begin
      if (do_push) store_r[wr_ptr_r] <= push_data;
   end

endmodule : bms_msg_queue

// *** bms_irq_gate.sv ***
// One interrupt channel: enable and level gating of a pending condition
`timescale 1ns/1ns
module bms_irq_gate (
   // Condition and its control register
   input  wire logic       pending,
   input  wire logic [3:0] icr,
   // Requested level, zero when silent
   output logic [2:0]      level
);
   logic enabled;

   assign enabled = icr[bms_pkg::ICR_EN_BIT];
   // Level code zero also silences the channel
   assign level   = (pending && enabled) ? icr[bms_pkg::ICR_LVL_MSB:bms_pkg::ICR_LVL_LSB] : 3'h0;

endmodule : bms_irq_gate

// *** bms_slave_asserts.sv ***
// Port-level checker for the broadcast receive slave
`timescale 1ns/1ns
module bms_slave_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Local access
   input wire logic        cpu_req,
   input wire logic        cpu_wr,
   input wire logic [31:0] cpu_addr,
   input wire logic [31:0] cpu_wdata,
   input wire logic [31:0] cpu_rdata_r,
   input wire logic        cpu_ack_r,
   input wire logic        cpu_berr_r,
   // Broadcast side
   input wire logic        vme_req,
   input wire logic        vme_wr,
   input wire logic [31:0] vme_addr,
   input wire logic [5:0]  vme_am,
   input wire logic [7:0]  vme_data,
   input wire logic        vme_ack_r,
   input wire logic        vme_refused_r,
   // Interrupt request
   input wire logic [2:0]  irq_level_r,
   input wire logic [1:0]  irq_source_r
);
   logic [7:0] ctl_r, area_r;
   logic [3:0] icr_r [4], icr_d_r [4];
   wire        wtake   = cpu_req && cpu_wr;
   wire        silent  = !vme_ack_r && !vme_refused_r;
   wire        ro_addr = cpu_addr == bms_pkg::ADDR_READOUT_CH0 || cpu_addr == bms_pkg::ADDR_READOUT_CH1;
   wire [4:0]  slot    = ctl_r[4:0];

   // Shadow copies; the delayed ICR matches the one-cycle lag of the irq outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r  <= 8'h00;
         area_r <= 8'h00;
         for (int i = 0; i < 4; i++) begin
            icr_r[i]   <= 4'h0;
            icr_d_r[i] <= 4'h0;
         end
      end else begin
         if (wtake && cpu_addr == bms_pkg::ADDR_CONTROL) ctl_r <= cpu_wdata[7:0];
         if (wtake && cpu_addr == bms_pkg::ADDR_AREA) area_r <= cpu_wdata[7:0];
         for (int i = 0; i < 4; i++) begin
            if (wtake && cpu_addr == bms_pkg::ADDR_ICR[i]) icr_r[i] <= cpu_wdata[3:0];
            icr_d_r[i] <= icr_r[i];
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_AREA_MISS: assert property (
      vme_req && vme_addr[31:24] != area_r |=> silent) else $error("answer outside broadcast area");
   AST_NON_WRITE: assert property (
      vme_req && !vme_wr |=> silent) else $error("answer to a non-write cycle");
   AST_AM_CODE: assert property (
      vme_req && vme_am != bms_pkg::AM_EXT_SUPER && !(ctl_r[7] && vme_am == bms_pkg::AM_EXT_USER) |=> silent)
      else $error("answer to a disallowed modifier");
   AST_CHAN_OFF: assert property (
      vme_req && !ctl_r[vme_addr[2] ? 6 : 5] |=> silent) else $error("answer on a disabled channel");
   AST_SLOT: assert property (
      vme_req && (slot == 5'h00 || slot > 5'h15 || !vme_addr[slot + 2]) |=> silent)
      else $error("answer without slot select");
   AST_ONE_ANSWER: assert property (
      !(vme_ack_r && vme_refused_r)) else $error("accepted and refused together");
   AST_RO_WRITE: assert property (
      wtake && ro_addr |=> cpu_berr_r && !cpu_ack_r) else $error("readout write not refused");
   AST_RO_UPPER: assert property (
      cpu_req && !cpu_wr && ro_addr |=> cpu_berr_r || cpu_rdata_r[31:8] == 24'h00_0000)
      else $error("readout upper bits set");
   AST_CPU_ANSWER: assert property (
      cpu_req |=> cpu_ack_r != cpu_berr_r) else $error("local access without single answer");
   AST_IRQ_GATED: assert property (
      irq_level_r != 3'h0 |-> icr_d_r[irq_source_r][3] && icr_d_r[irq_source_r][2:0] == irq_level_r)
      else $error("irq level not from an enabled source");
endmodule : bms_slave_asserts

bind bms_slave bms_slave_asserts i_bms_slave_asserts (
   .clk, .rst_n, .cpu_req, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata_r, .cpu_ack_r, .cpu_berr_r,
   .vme_req, .vme_wr, .vme_addr, .vme_am, .vme_data, .vme_ack_r, .vme_refused_r, .irq_level_r, .irq_source_r);

// *** bms_vme_master.sv ***
// Broadcasting system-bus master model
`timescale 1ns/1ns
module bms_vme_master (
   // Clock
   input  wire logic        clk,
   // Cycle to the slave
   output logic             vme_req,
   output logic             vme_wr,
   output logic [31:0]      vme_addr,
   output logic [5:0]       vme_am,
   output logic [7:0]       vme_data,
   // Answer from the slave
   input  wire logic        vme_ack_r,
   input  wire logic        vme_refused_r
);
   initial begin
      vme_req  = 1'b0;
      vme_wr   = 1'b0;
      vme_addr = 32'h0000_0000;
      vme_am   = 6'h00;
      vme_data = 8'h00;
   end

   task automatic send(input logic wr, input logic [31:0] a, input logic [5:0] am, input logic [7:0] d,
                       output logic [1:0] resp);
      @(posedge clk);
      vme_req  <= 1'b1;
      vme_wr   <= wr;
      vme_addr <= a;
      vme_am   <= am;
      vme_data <= d;
      @(posedge clk);
      vme_req  <= 1'b0;
      vme_addr <= ~a;
      vme_data <= ~d;
      #1;
      resp = {vme_ack_r, vme_refused_r};
   endtask : send
endmodule : bms_vme_master

// *** bms_slave_tb_top.sv ***
// Self-checking bench for the broadcast receive slave
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module bms_slave_tb_top;
   logic        clk, rst_n, cpu_req, cpu_wr, cpu_ack_r, cpu_berr_r, vme_req, vme_wr, vme_ack_r, vme_refused_r;
   logic [31:0] cpu_addr, cpu_wdata, cpu_rdata_r, vme_addr;
   logic [5:0]  vme_am;
   logic [7:0]  vme_data;
   logic [2:0]  irq_level_r;
   logic [1:0]  irq_source_r, resp;
   int          err_count, tests_run, cycles;
   localparam logic [31:0] CH0_VA = 32'hA500_0080;
   localparam logic [31:0] CH1_VA = 32'hA500_0084;

   bms_slave i_bms_slave (.clk, .rst_n, .cpu_req, .cpu_wr, .cpu_addr, .cpu_wdata, .cpu_rdata_r, .cpu_ack_r,
      .cpu_berr_r, .vme_req, .vme_wr, .vme_addr, .vme_am, .vme_data, .vme_ack_r, .vme_refused_r,
      .irq_level_r, .irq_source_r);
   bms_vme_master i_bms_vme_master (.clk, .vme_req, .vme_wr, .vme_addr, .vme_am, .vme_data, .vme_ack_r,
      .vme_refused_r);

   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("Counts: %0d compared, %0d mismatched", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic cpu(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      cpu_req   <= 1'b1;
      cpu_wr    <= wr;
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge clk);
      cpu_req   <= 1'b0;
      cpu_wdata <= ~d;
      #1;
   endtask : cpu
   // Read expecting data, or a bus error when eb is set
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic eb);
      cpu(1'b0, a, 32'h0000_0000);
      `CHK({cpu_ack_r, cpu_berr_r, cpu_rdata_r}, {~eb, eb, e})
   endtask : rd
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic eb);
      cpu(1'b1, a, d);
      `CHK({cpu_ack_r, cpu_berr_r}, {~eb, eb})
   endtask : wr
   // Expected answer: 10 accepted, 01 refused, 00 ignored
   task automatic bc(input logic [31:0] a, input logic [5:0] am, input logic [7:0] d, input logic [1:0] e);
      i_bms_vme_master.send(1'b1, a, am, d, resp);
      `CHK(resp, e)
   endtask : bc
   task automatic irq(input logic [2:0] l, input logic [1:0] s);
      repeat (3) @(posedge clk);
      #1;
      `CHK({irq_level_r, irq_source_r}, {l, s})
   endtask : irq

   initial begin
      clk       = 1'b0;
      rst_n     = 1'b0;
      cpu_req   = 1'b0;
      cpu_wr    = 1'b0;
      cpu_addr  = 32'h0000_0000;
      cpu_wdata = 32'h0000_0000;
      err_count = 0;
      tests_run = 0;
      cycles    = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(bms_pkg::ADDR_CONTROL, 32'h0000_0000, 1'b0);
      rd(bms_pkg::ADDR_AREA, 32'h0000_0000, 1'b0);
      for (int i = 0; i < 4; i++) rd(bms_pkg::ADDR_ICR[i], 32'h0000_0000, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH0_MSG, 32'h0000_0080, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH1_MSG, 32'h0000_0080, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH0_REF, 32'h0000_0080, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH1_REF, 32'h0000_0080, 1'b0);
      rd(32'hFFD0_0250, 32'h0000_0000, 1'b1);
      $display("test reset_values done");
      wr(bms_pkg::ADDR_CONTROL, 32'h0000_0065, 1'b0);
      rd(bms_pkg::ADDR_CONTROL, 32'h0000_0065, 1'b0);
      wr(bms_pkg::ADDR_AREA, 32'h0000_00A5, 1'b0);
      rd(bms_pkg::ADDR_AREA, 32'h0000_00A5, 1'b0);
      for (int i = 0; i < 4; i++) begin
         wr(bms_pkg::ADDR_ICR[i], 32'h0000_00F9 + i, 1'b0);
         rd(bms_pkg::ADDR_ICR[i], 32'h0000_0009 + i, 1'b0);
      end
      $display("test config done");
      bc(32'hA400_0080, 6'h0D, 8'h11, 2'b00);
      bc(32'h2500_0080, 6'h0D, 8'h11, 2'b00);
      bc(32'hA500_0040, 6'h0D, 8'h11, 2'b00);
      bc(CH0_VA, 6'h09, 8'h11, 2'b00);
      wr(bms_pkg::ADDR_CONTROL, 32'h0000_0045, 1'b0);
      bc(CH0_VA, 6'h0D, 8'h11, 2'b00);
      wr(bms_pkg::ADDR_CONTROL, 32'h0000_00E5, 1'b0);
      i_bms_vme_master.send(1'b0, CH0_VA, 6'h0D, 8'h11, resp);
      `CHK(resp, 2'b00)
      rd(bms_pkg::ADDR_ISR_CH0_MSG, 32'h0000_0080, 1'b0);
      irq(3'h0, 2'h0);
      $display("test filtering done");
      for (int i = 0; i < 8; i++) bc(CH0_VA, (i == 0) ? 6'h09 : 6'h0D, 8'(8'h10 + i), 2'b10);
      bc(CH0_VA, 6'h0D, 8'h77, 2'b01);
      rd(bms_pkg::ADDR_ISR_CH0_MSG, 32'h0000_0000, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH0_REF, 32'h0000_0000, 1'b0);
      irq(3'h2, 2'h1);
      wr(bms_pkg::ADDR_ISR_CH0_REF, 32'h0000_0000, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH0_REF, 32'h0000_0080, 1'b0);
      irq(3'h1, 2'h0);
      for (int i = 0; i < 8; i++) rd(bms_pkg::ADDR_READOUT_CH0, 32'h0000_0010 + i, 1'b0);
      rd(bms_pkg::ADDR_READOUT_CH0, 32'h0000_0000, 1'b1);
      rd(bms_pkg::ADDR_ISR_CH0_MSG, 32'h0000_0080, 1'b0);
      wr(bms_pkg::ADDR_READOUT_CH0, 32'h0000_0001, 1'b1);
      irq(3'h0, 2'h0);
      $display("test channel0 done");
      bc(CH1_VA, 6'h0D, 8'h5A, 2'b10);
      bc(CH1_VA, 6'h0D, 8'hA5, 2'b01);
      rd(bms_pkg::ADDR_ISR_CH1_MSG, 32'h0000_0000, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH1_REF, 32'h0000_0000, 1'b0);
      irq(3'h4, 2'h3);
      wr(bms_pkg::ADDR_ICR_CH1_REF, 32'h0000_0004, 1'b0);
      irq(3'h3, 2'h2);
      wr(bms_pkg::ADDR_ICR_CH1_MSG, 32'h0000_0008, 1'b0);
      irq(3'h0, 2'h0);
      rd(bms_pkg::ADDR_READOUT_CH0, 32'h0000_0000, 1'b1);
      rd(bms_pkg::ADDR_READOUT_CH1, 32'h0000_005A, 1'b0);
      rd(bms_pkg::ADDR_READOUT_CH1, 32'h0000_0000, 1'b1);
      rd(bms_pkg::ADDR_ISR_CH1_MSG, 32'h0000_0080, 1'b0);
      wr(bms_pkg::ADDR_ISR_CH1_REF, 32'h0000_00FF, 1'b0);
      rd(bms_pkg::ADDR_ISR_CH1_REF, 32'h0000_0080, 1'b0);
      bc(CH1_VA, 6'h0D, 8'h3C, 2'b10);
      $display("test channel1 done");
      end_sim();
   end
endmodule : bms_slave_tb_top
